// [logic/alm_defs.svh]
// Constants for the layer-4 field matcher.
`ifndef ALM_DEFS_SVH
`define ALM_DEFS_SVH
`define ALM_A_PROTO 12'h000
`define ALM_A_ICMP 12'h004
`define ALM_A_SPORT 12'h008
`define ALM_A_SRNG 12'h00C
`define ALM_A_DPORT 12'h010
`define ALM_A_DRNG 12'h014
`define ALM_A_FLAGS 12'h018
`define ALM_A_STAT 12'h01C
`define ALM_PR_ANY 2'h0
`define ALM_PR_ICMP 2'h1
`define ALM_PR_UDP 2'h2
`define ALM_PR_TCP 2'h3
`define ALM_SEL_ANY 2'h0
`define ALM_SEL_SPEC 2'h1
`define ALM_SEL_RANGE 2'h2
`define ALM_FL_ZERO 2'h0
`define ALM_FL_ONE 2'h1
`define ALM_FL_ANY 2'h2
`define ALM_NFLAGS 6
`define ALM_LATENCY 2
`define ALM_RST_HI 16'hFFFF
`define ALM_RST_FLAGS 12'hAAA
`define ALM_F_PROTO 1:0
`define ALM_F_TYPE 7:0
`define ALM_F_CODE 15:8
`define ALM_F_TSEL 17:16
`define ALM_F_CSEL 25:24
`define ALM_F_VAL 15:0
`define ALM_F_SEL 17:16
`define ALM_F_LO 15:0
`define ALM_F_HI 31:16
`define ALM_F_FLAGS 11:0
`endif

// [logic/alm_matcher.sv]
// Layer-4 match logic for one access_control_entry with an AHB-Lite register slave.
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// - ICMP type Any ignores type field.
// - ICMP type Specific needs exact equality.
// - ICMP code Any is don't-care.
// - ICMP code Specific needs exact equality.
// - Source port Any is ignored.
// - Source port Specific needs exact equality.
// - Source port Range checks both bounds.
// - Destination port Any is don't-care.
// - Destination port Specific needs exact equality.
// - Destination port Range checks both bounds.
// - FIN condition zero, one or any.
// - SYN condition zero, one or any.
// - PSH condition zero, one or any.
// - ACK condition zero, one or any.
// - URG condition zero, one or any.
// - Protocol selection picks which conditions apply.
`include "alm_defs.svh"
module alm_matcher (
  input wire logic CLK, // Switch clock, 40 MHz.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic HSEL, // Slave select.
  input wire logic [11:0] HADDR, // Byte address.
  input wire logic [1:0] HTRANS, // Transfer type.
  input wire logic HWRITE, // Write when high.
  input wire logic [2:0] HSIZE, // Transfer size.
  input wire logic [31:0] HWDATA, // Write data.
  input wire logic HREADY, // Bus ready in.
  output logic [31:0] HRDATA, // Read data.
  output logic HREADYOUT, // Slave ready.
  output logic HRESP, // Always OKAY.
  input wire logic HDR_VALID, // Header fields valid strobe.
  input wire alm_pkg::alm_hdr_s HDR, // Header fields.
  output logic MATCH_VALID, // Decision strobe.
  output logic MATCH // Entry matched.
);
  import alm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] proto_reg;
  logic [1:0] icmp_tsel_reg;
  logic [1:0] icmp_csel_reg;
  logic [7:0] icmp_type_reg;
  logic [7:0] icmp_code_reg;
  logic [1:0] ssel_reg;
  logic [1:0] dsel_reg;
  logic [15:0] sval_reg;
  logic [15:0] slo_reg;
  logic [15:0] shi_reg;
  logic [15:0] dval_reg;
  logic [15:0] dlo_reg;
  logic [15:0] dhi_reg;
  logic [11:0] flag_cfg_reg;
  logic [15:0] match_cnt_reg;
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] rdata_next;

  // The slave answers every transfer with zero wait states.
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Address phase capture for writes.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else if (HREADY) begin
      wr_pend_reg <= HSEL && HTRANS[1] && HWRITE;
      wr_addr_reg <= HADDR;
    end
  end

  // Configuration writes; unmapped addresses are ignored.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      proto_reg <= `ALM_PR_ANY;
      icmp_tsel_reg <= `ALM_SEL_ANY;
      icmp_csel_reg <= `ALM_SEL_ANY;
      icmp_type_reg <= 8'h00;
      icmp_code_reg <= 8'h00;
      ssel_reg <= `ALM_SEL_ANY;
      dsel_reg <= `ALM_SEL_ANY;
      sval_reg <= 16'h0000;
      slo_reg <= 16'h0000;
      shi_reg <= `ALM_RST_HI;
      dval_reg <= 16'h0000;
      dlo_reg <= 16'h0000;
      dhi_reg <= `ALM_RST_HI;
      flag_cfg_reg <= `ALM_RST_FLAGS;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        `ALM_A_PROTO: proto_reg <= HWDATA[`ALM_F_PROTO];
        `ALM_A_ICMP: begin
          icmp_type_reg <= HWDATA[`ALM_F_TYPE];
          icmp_code_reg <= HWDATA[`ALM_F_CODE];
          icmp_tsel_reg <= HWDATA[`ALM_F_TSEL];
          icmp_csel_reg <= HWDATA[`ALM_F_CSEL];
        end
        `ALM_A_SPORT: begin
          sval_reg <= HWDATA[`ALM_F_VAL];
          ssel_reg <= HWDATA[`ALM_F_SEL];
        end
        `ALM_A_SRNG: begin
          slo_reg <= HWDATA[`ALM_F_LO];
          shi_reg <= HWDATA[`ALM_F_HI];
        end
        `ALM_A_DPORT: begin
          dval_reg <= HWDATA[`ALM_F_VAL];
          dsel_reg <= HWDATA[`ALM_F_SEL];
        end
        `ALM_A_DRNG: begin
          dlo_reg <= HWDATA[`ALM_F_LO];
          dhi_reg <= HWDATA[`ALM_F_HI];
        end
        `ALM_A_FLAGS: flag_cfg_reg <= HWDATA[`ALM_F_FLAGS];
        default: ;
      endcase
    end
  end

  // Read mux for the address phase; data appears in the data phase.
  always_comb begin
    rdata_next = 32'h00000000;
    case (HADDR)
      `ALM_A_PROTO: rdata_next = {30'h0, proto_reg};
      `ALM_A_ICMP: rdata_next = {6'h0, icmp_csel_reg, 6'h0, icmp_tsel_reg,
                                 icmp_code_reg, icmp_type_reg};
      `ALM_A_SPORT: rdata_next = {14'h0, ssel_reg, sval_reg};
      `ALM_A_SRNG: rdata_next = {shi_reg, slo_reg};
      `ALM_A_DPORT: rdata_next = {14'h0, dsel_reg, dval_reg};
      `ALM_A_DRNG: rdata_next = {dhi_reg, dlo_reg};
      `ALM_A_FLAGS: rdata_next = {20'h0, flag_cfg_reg};
      `ALM_A_STAT: rdata_next = {16'h0, match_cnt_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Registered read data.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h00000000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HRDATA <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage one: register the header.
  logic hv_reg;
  alm_hdr_s hdr_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hv_reg <= 1'b0;
      hdr_reg <= '0;
    end else begin
      hv_reg <= HDR_VALID;
      if (HDR_VALID) begin
        hdr_reg <= HDR;
      end
    end
  end

  // Per-flag checks; flag index 0..5 is FIN,SYN,RST,PSH,ACK,URG.
  logic [`ALM_NFLAGS-1:0] flag_ok;
  genvar gi;
  generate
    for (gi = 0; gi < `ALM_NFLAGS; gi++) begin : g_flag
      logic [1:0] fsel;
      assign fsel = flag_cfg_reg[2*gi+1:2*gi];
      assign flag_ok[gi] = (fsel == `ALM_FL_ZERO) ? !hdr_reg.flags[gi] :
                           (fsel == `ALM_FL_ONE) ? hdr_reg.flags[gi] :
                           1'b1;
    end
  endgenerate

  // Port and ICMP condition checks.
  logic icmp_t_ok;
  logic icmp_c_ok;
  logic sp_ok;
  logic dp_ok;
  logic proto_ok;
  logic l4_ok;
  assign icmp_t_ok = (icmp_tsel_reg != `ALM_SEL_SPEC) ||
                     (hdr_reg.icmp_type == icmp_type_reg);
  assign icmp_c_ok = (icmp_csel_reg != `ALM_SEL_SPEC) ||
                     (hdr_reg.icmp_code == icmp_code_reg);
  assign sp_ok = (ssel_reg == `ALM_SEL_SPEC) ? (hdr_reg.sport == sval_reg) :
                 (ssel_reg == `ALM_SEL_RANGE) ?
                 (hdr_reg.sport >= slo_reg && hdr_reg.sport <= shi_reg) : 1'b1;
  assign dp_ok = (dsel_reg == `ALM_SEL_SPEC) ? (hdr_reg.dport == dval_reg) :
                 (dsel_reg == `ALM_SEL_RANGE) ?
                 (hdr_reg.dport >= dlo_reg && hdr_reg.dport <= dhi_reg) : 1'b1;
  // Protocol selection decides which conditions are applied.
  always_comb begin
    proto_ok = 1'b1;
    l4_ok = 1'b1;
    case (proto_reg)
      `ALM_PR_ICMP: begin
        proto_ok = hdr_reg.is_ipv4 && (hdr_reg.proto == `ALM_PR_ICMP);
        l4_ok = icmp_t_ok && icmp_c_ok;
      end
      `ALM_PR_UDP: begin
        proto_ok = hdr_reg.is_ipv4 && (hdr_reg.proto == `ALM_PR_UDP);
        l4_ok = sp_ok && dp_ok;
      end
      `ALM_PR_TCP: begin
        proto_ok = hdr_reg.is_ipv4 && (hdr_reg.proto == `ALM_PR_TCP);
        l4_ok = sp_ok && dp_ok && (&flag_ok);
      end
      default: begin
        proto_ok = 1'b1;
        l4_ok = 1'b1;
      end
    endcase
  end

  // Stage two: register the decision.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MATCH_VALID <= 1'b0;
      MATCH <= 1'b0;
    end else begin
      MATCH_VALID <= hv_reg;
      MATCH <= hv_reg && proto_ok && l4_ok;
    end
  end

  // Count of matches, visible in the status register.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      match_cnt_reg <= 16'h0000;
    end else if (MATCH_VALID && MATCH) begin
      match_cnt_reg <= match_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the decision pipeline.
  sequence s_hdr_in;
    HDR_VALID;
  endsequence
  // Registered header under a TCP entry, the first step of the RST flag check.
  sequence s_tcp_hdr;
    hv_reg && proto_reg == `ALM_PR_TCP;
  endsequence
  // Registered header under a port-bearing entry, the first step of the port range checks.
  sequence s_port_hdr;
    hv_reg && (proto_reg == `ALM_PR_UDP || proto_reg == `ALM_PR_TCP);
  endsequence

  AST_LATENCY: assert property (@(posedge CLK) disable iff (!RST_N)
    s_hdr_in |-> ##`ALM_LATENCY MATCH_VALID)
    else $error("Decision strobe missing two cycles after header.");
  AST_NO_SPURIOUS: assert property (@(posedge CLK) disable iff (!RST_N)
    MATCH_VALID |-> $past(HDR_VALID, `ALM_LATENCY))
    else $error("Decision strobe without a header.");
  AST_MATCH_QUAL: assert property (@(posedge CLK) disable iff (!RST_N)
    MATCH |-> MATCH_VALID)
    else $error("Match raised without decision strobe.");
  AST_SPORT_SPEC: assert property (@(posedge CLK) disable iff (!RST_N)
    hv_reg && ssel_reg == `ALM_SEL_SPEC && proto_reg == `ALM_PR_UDP &&
    hdr_reg.sport != sval_reg |=> !MATCH)
    else $error("Source port mismatch matched.");
  AST_DPORT_RANGE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_port_hdr ##0 (dsel_reg == `ALM_SEL_RANGE &&
    (hdr_reg.dport < dlo_reg || hdr_reg.dport > dhi_reg)) |=> !MATCH)
    else $error("Destination port outside range matched.");
  AST_ICMP_TYPE: assert property (@(posedge CLK) disable iff (!RST_N)
    hv_reg && proto_reg == `ALM_PR_ICMP && icmp_tsel_reg == `ALM_SEL_SPEC &&
    hdr_reg.icmp_type != icmp_type_reg |=> !MATCH)
    else $error("ICMP type mismatch matched.");
  AST_FIN_ZERO: assert property (@(posedge CLK) disable iff (!RST_N)
    hv_reg && proto_reg == `ALM_PR_TCP && flag_cfg_reg[1:0] == `ALM_FL_ZERO &&
    hdr_reg.flags[0] |=> !MATCH)
    else $error("FIN set matched a zero condition.");
  AST_SYN_ONE: assert property (@(posedge CLK) disable iff (!RST_N)
    hv_reg && proto_reg == `ALM_PR_TCP && flag_cfg_reg[3:2] == `ALM_FL_ONE &&
    !hdr_reg.flags[1] |=> !MATCH)
    else $error("SYN clear matched a one condition.");
  AST_PROTO: assert property (@(posedge CLK) disable iff (!RST_N)
    hv_reg && proto_reg == `ALM_PR_UDP && hdr_reg.proto != `ALM_PR_UDP |=> !MATCH)
    else $error("Non-UDP frame matched a UDP entry.");
  AST_ANY_ALL: assert property (@(posedge CLK) disable iff (!RST_N)
    hv_reg && proto_reg == `ALM_PR_ANY |=> MATCH)
    else $error("Unrestricted entry failed to match.");
  AST_RST_ZERO: assert property (@(posedge CLK) disable iff (!RST_N)
    s_tcp_hdr ##0 (flag_cfg_reg[5:4] == `ALM_FL_ZERO && hdr_reg.flags[2]) |=> !MATCH)
    else $error("RST set matched a zero condition.");
  AST_SPORT_RANGE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_port_hdr ##0 (ssel_reg == `ALM_SEL_RANGE &&
    (hdr_reg.sport < slo_reg || hdr_reg.sport > shi_reg)) |=> !MATCH)
    else $error("Source port outside range matched.");
  AST_ICMP_CODE: assert property (@(posedge CLK) disable iff (!RST_N)
    hv_reg && proto_reg == `ALM_PR_ICMP && icmp_csel_reg == `ALM_SEL_SPEC &&
    hdr_reg.icmp_code != icmp_code_reg |=> !MATCH)
    else $error("ICMP code mismatch matched.");
  AST_IPV4_ONLY: assert property (@(posedge CLK) disable iff (!RST_N)
    hv_reg && proto_reg != `ALM_PR_ANY && !hdr_reg.is_ipv4 |=> !MATCH)
    else $error("Non-IPv4 frame matched a protocol entry.");
endmodule : alm_matcher

// [logic/alm_pkg.sv]
// Types shared by the layer-4 field matcher.
package alm_pkg;
  // Header fields presented by the ingress parser.
  typedef struct packed {
    logic is_ipv4;
    logic [1:0] proto;
    logic [7:0] icmp_type;
    logic [7:0] icmp_code;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [5:0] flags;
  } alm_hdr_s;
endpackage : alm_pkg

// [verif/alm_matcher_bench.sv]
// Self-checking testbench for the layer-4 field matcher.
`timescale 1ns/1ps
`include "alm_defs.svh"
module alm_matcher_bench;
  import alm_pkg::*;
  logic clk, rst_n, hwrite, send, hdr_valid, match_valid, match, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rdata;
  alm_hdr_s hdr_in, hdr;
  int bad_count = 0;
  int num_checks = 0;
  int n_match = 0;
  logic v4 = 1'b1;
  int i;
  ////////////////////////////////////////////////////////////////////////////
  // Design and parser model.
  alm_matcher i_alm_matcher (.CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .HDR_VALID(hdr_valid),
    .HDR(hdr), .MATCH_VALID(match_valid), .MATCH(match));
  alm_parser_model i_alm_parser_model (.CLK(clk), .SEND(send), .HDR_IN(hdr_in),
    .HDR_VALID(hdr_valid), .HDR(hdr));
  ////////////////////////////////////////////////////////////////////////////
  // Compares, counts and reports.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Waits for bus ready under a bound; a hang ends the run.
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      report_and_stop();
    end
  endtask : rdy
  // One single-word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rdata = hrdata;
  endtask : bus
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rdc
  // Sends one header; the model shows it one edge later, the decision stands two edges on.
  task automatic frame(input logic [1:0] pr, input logic [7:0] it, input logic [7:0] ic,
      input logic [15:0] sp, input logic [15:0] dp, input logic [5:0] fl, input logic ex);
    send <= 1'b1;
    hdr_in <= '{v4, pr, it, ic, sp, dp, fl};
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({31'h0, match_valid}, 32'h0);
    @(posedge clk);
    @(negedge clk);
    chk({30'h0, match_valid, match}, {30'h0, 1'b1, ex});
    @(posedge clk);
    if (ex) n_match++;
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_defaults;
    rdc(`ALM_A_FLAGS, 32'h0000_0AAA);
    rdc(`ALM_A_SRNG, 32'hFFFF_0000);
    bus(1'b1, 12'h020, 32'hFFFF_FFFF);
    rdc(12'h020, 32'h0);
    frame(2'h0, 8'h11, 8'h22, 16'h3344, 16'h5566, 6'h3F, 1'b1);
  endtask : t_defaults
  task automatic t_icmp;
    bus(1'b1, `ALM_A_PROTO, 32'h1);
    bus(1'b1, `ALM_A_ICMP, 32'h0001_0008);
    frame(2'h1, 8'h08, 8'h4D, 16'h0, 16'h0, 6'h0, 1'b1);
    frame(2'h1, 8'h09, 8'h00, 16'h0, 16'h0, 6'h0, 1'b0);
    bus(1'b1, `ALM_A_ICMP, 32'h0100_FF00);
    frame(2'h1, 8'h03, 8'hFF, 16'h0, 16'h0, 6'h0, 1'b1);
    frame(2'h1, 8'h03, 8'hFE, 16'h0, 16'h0, 6'h0, 1'b0);
  endtask : t_icmp
  task automatic t_ports;
    bus(1'b1, `ALM_A_PROTO, 32'h2);
    bus(1'b1, `ALM_A_SPORT, 32'h0001_0000);
    bus(1'b1, `ALM_A_DPORT, 32'h0002_0000);
    bus(1'b1, `ALM_A_DRNG, 32'hFFFF_0050);
    frame(2'h2, 8'h0, 8'h0, 16'h0000, 16'h0050, 6'h0, 1'b1);
    frame(2'h2, 8'h0, 8'h0, 16'h0000, 16'h004F, 6'h0, 1'b0);
    frame(2'h2, 8'h0, 8'h0, 16'h0000, 16'hFFFF, 6'h0, 1'b1);
    frame(2'h2, 8'h0, 8'h0, 16'h0001, 16'h0050, 6'h0, 1'b0);
    frame(2'h3, 8'h0, 8'h0, 16'h0000, 16'h0050, 6'h0, 1'b0);
    v4 = 1'b0;
    frame(2'h2, 8'h0, 8'h0, 16'h0000, 16'h0050, 6'h0, 1'b0);
    v4 = 1'b1;
    bus(1'b1, `ALM_A_SPORT, 32'h0002_0000);
    bus(1'b1, `ALM_A_SRNG, 32'h03E8_03E8);
    bus(1'b1, `ALM_A_DPORT, 32'h0001_FFFF);
    frame(2'h2, 8'h0, 8'h0, 16'h03E8, 16'hFFFF, 6'h0, 1'b1);
    frame(2'h2, 8'h0, 8'h0, 16'h03E9, 16'hFFFF, 6'h0, 1'b0);
    frame(2'h2, 8'h0, 8'h0, 16'h03E7, 16'hFFFF, 6'h0, 1'b0);
    frame(2'h2, 8'h0, 8'h0, 16'h03E8, 16'hFFFE, 6'h0, 1'b0);
    bus(1'b1, `ALM_A_SPORT, 32'h0);
    bus(1'b1, `ALM_A_DPORT, 32'h0);
    frame(2'h2, 8'h0, 8'h0, 16'h1234, 16'h4321, 6'h0, 1'b1);
  endtask : t_ports
  task automatic t_flags;
    logic [31:0] f;
    bus(1'b1, `ALM_A_PROTO, 32'h3);
    for (i = 0; i < 6; i++) begin
      f = 32'hAAA & ~(32'h3 << (2 * i));
      bus(1'b1, `ALM_A_FLAGS, f);
      frame(2'h3, 8'h0, 8'h0, 16'h0, 16'h0, 6'h1 << i, 1'b0);
      frame(2'h3, 8'h0, 8'h0, 16'h0, 16'h0, 6'h0, 1'b1);
      bus(1'b1, `ALM_A_FLAGS, f | (32'h1 << (2 * i)));
      frame(2'h3, 8'h0, 8'h0, 16'h0, 16'h0, 6'h1 << i, 1'b1);
      frame(2'h3, 8'h0, 8'h0, 16'h0, 16'h0, 6'h0, 1'b0);
    end
    bus(1'b1, `ALM_A_FLAGS, 32'hAAA);
    frame(2'h3, 8'h0, 8'h0, 16'h0, 16'h0, 6'h3F, 1'b1);
    bus(1'b1, `ALM_A_FLAGS, 32'hFFF);
    frame(2'h3, 8'h0, 8'h0, 16'h0, 16'h0, 6'h15, 1'b1);
  endtask : t_flags
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Main sequence: reset, register defaults, then each scenario.
  initial begin
    rst_n = 1'b0;
    send = 1'b0;
    hdr_in = '0;
    htrans = 2'h0;
    haddr = 12'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_icmp();
    t_ports();
    t_flags();
    rdc(`ALM_A_STAT, n_match);
    report_and_stop();
  end
endmodule : alm_matcher_bench

// [verif/alm_parser_model.sv]
// Behavioural model of the ingress parser that feeds header fields.
`timescale 1ns/1ps
module alm_parser_model (
  input wire logic CLK, // Switch clock.
  input wire logic SEND, // One-cycle request from the bench.
  input wire alm_pkg::alm_hdr_s HDR_IN, // Header fields to present.
  output logic HDR_VALID, // Header strobe.
  output alm_pkg::alm_hdr_s HDR // Header fields.
);
  import alm_pkg::*;
  // Outputs start idle so the matcher never sees an unknown strobe.
  initial begin
    HDR_VALID = 1'b0;
    HDR = '0;
  end
  // Present a header for one cycle, then invert the fields on every idle cycle, so the stale header comes back on alternate cycles.
  always @(posedge CLK) begin
    HDR_VALID <= SEND;
    HDR <= SEND ? HDR_IN : ~HDR;
  end
endmodule : alm_parser_model
